// ### spc_pkg.sv
// Shared constants and carriers for the per-port switch control and statistics block
// Operation
// - Disabled port neither receives nor transmits
// - Auto negotiation or forced speed/duplex
// - Speed/duplex writable only in forced mode
// - Flow control on: send PAUSE when congested
// - Flow control off: drop unprocessable frames
// - Ingress limit 0..8000 times 128 kbit/s
// - Egress limit 0..8000 times 128 kbit/s
// - Secure port: no learning, known sources only
// - Per-port broadcast storm filter enable
// - Per-port jumbo frame enable
// - Report per-port link up or down
// - Report per-port established speed
// - Count good transmitted frames
// - Count bad transmitted frames
// - Count good received frames
// - Count bad received frames
// - Count aborted transmissions
// - Count collisions and dropped frames
// - Count received broadcast and multicast frames
package spc_pkg;
    ////////////////////////////////////////////////////////////////////////////
    // Geometry
    localparam int NUM_PORTS = 24;
    localparam int NUM_CNT = 9;
    localparam int RATE_MAX = 8000;
    ////////////////////////////////////////////////////////////////////////////
    // Register map, byte addresses
    localparam logic [11:0] CFG_BASE = 12'h000;
    localparam logic [11:0] RATE_BASE = 12'h080;
    localparam logic [11:0] STAT_BASE = 12'h100;
    localparam logic [11:0] CNT_BASE = 12'h200;
    localparam logic [4:0] CNT_PORT_OFS = 5'h08;
    // Counter indices inside one port's counter block
    localparam int CNT_TX_GOOD = 0;
    localparam int CNT_TX_BAD = 1;
    localparam int CNT_RX_GOOD = 2;
    localparam int CNT_RX_BAD = 3;
    localparam int CNT_TX_ABORT = 4;
    localparam int CNT_COLL = 5;
    localparam int CNT_DROP = 6;
    localparam int CNT_BCAST = 7;
    localparam int CNT_MCAST = 8;
    ////////////////////////////////////////////////////////////////////////////
    // Config word fields
    localparam int CFG_EN = 0;
    localparam int CFG_AUTO = 1;
    localparam int CFG_SPD_LO = 2;
    localparam int CFG_DUPLEX = 4;
    localparam int CFG_FC = 5;
    localparam int CFG_SECURE = 6;
    localparam int CFG_STORM = 7;
    localparam int CFG_JUMBO = 8;
    localparam logic [8:0] CFG_RESET = 9'h003;
    localparam int RATE_EG_LO = 16;
    ////////////////////////////////////////////////////////////////////////////
    // Rate meter timing: one refill every 125 us, 2 bytes per 128 kbit/s unit
    localparam int CLK_PERIOD_PS = 5000;
    localparam int REFILL_PERIOD_NS = 125000;
    localparam int REFILL_CYCLES = (REFILL_PERIOD_NS * 1000) / CLK_PERIOD_PS;
    localparam int BYTES_PER_UNIT = 2;
    localparam int BURST_BYTES = 32000;

    typedef struct packed {
        logic busy;
        logic eof;
        logic crc_err;
        logic runt;
        logic over;
        logic jumbo;
        logic bcast;
        logic mcast;
        logic sa_known;
        logic [13:0] len;
    } spc_rx_evt_t;

    typedef struct packed {
        logic busy;
        logic done;
        logic ok;
        logic abort;
        logic collision;
        logic [13:0] len;
    } spc_tx_evt_t;
endpackage

// ### spc_port_ctrl.sv
// Per-port control, rate metering and statistics with an APB register slave
//
// The implementer's own choices: the placing of the registers and the APB register port.
`timescale 1ns/100ps
module spc_port_ctrl #(
    parameter int NP = spc_pkg::NUM_PORTS,
    parameter int REFILL = spc_pkg::REFILL_CYCLES
) (
    // Clock, reset, enable
    input wire logic sys_clk_i,
    input wire logic reset_n_i,
    input wire logic clk_en_i,
    // APB slave
    input wire logic psel_i,
    input wire logic penable_i,
    input wire logic pwrite_i,
    input wire logic [11:0] paddr_i,
    input wire logic [31:0] pwdata_i,
    output logic [31:0] prdata_o,
    output logic pready_o,
    output logic pslverr_o,
    // PHY side
    input wire logic [NP-1:0] link_up_i,
    input wire logic [NP-1:0][1:0] neg_speed_i,
    input wire logic [NP-1:0] neg_duplex_i,
    // Switch core side
    input wire spc_pkg::spc_rx_evt_t rx_evt_i [NP],
    input wire spc_pkg::spc_tx_evt_t tx_evt_i [NP],
    input wire logic [NP-1:0] rx_congest_i,
    input wire logic [NP-1:0] storm_over_i,
    // Per-port controls
    output logic [NP-1:0] rx_forward_o,
    output logic [NP-1:0] tx_enable_o,
    output logic [NP-1:0] pause_req_o,
    output logic [NP-1:0] learn_en_o,
    output logic [NP-1:0] force_mode_o,
    output logic [NP-1:0][1:0] link_speed_o,
    output logic [NP-1:0] link_duplex_o,
    output logic [NP-1:0] broadcast_storm_filter_enable_o,
    output logic [NP-1:0] jumbo_en_o
);
    import spc_pkg::*;

    ////////////////////////////////////////////////////////////////////////////
    // Storage
    logic [8:0] cfg [NP];
    logic [8:0] act [NP];
    logic [12:0] in_rate [NP];
    logic [12:0] eg_rate [NP];
    logic [31:0] cnt [NP][NUM_CNT];
    logic [NP-1:0] lk_s1, lk_s2, lk_s3, link_q;
    logic [NP-1:0] in_over, eg_over;
    logic [15:0] tick_cnt;
    logic tick;

    ////////////////////////////////////////////////////////////////////////////
    // APB decode; setup phase latches the answer so read data comes from flops
    logic wr_stb, setup;
    logic [4:0] reg_port;
    logic [4:0] cnt_port;
    logic [3:0] cnt_idx;
    logic in_cfg, in_rate_rg, in_stat, in_cnt, mapped;
    logic [31:0] next_rdata;

    assign setup = psel_i && !penable_i;
    assign wr_stb = clk_en_i && psel_i && penable_i && pwrite_i && !pslverr_o;
    assign reg_port = paddr_i[6:2];
    assign cnt_port = 5'(paddr_i[10:6] - CNT_PORT_OFS);
    assign cnt_idx = paddr_i[5:2];
    assign in_cfg = (paddr_i[11:7] == CFG_BASE[11:7]) && (reg_port < 5'(NP));
    assign in_rate_rg = (paddr_i[11:7] == RATE_BASE[11:7]) && (reg_port < 5'(NP));
    assign in_stat = (paddr_i[11:7] == STAT_BASE[11:7]) && (reg_port < 5'(NP));
    assign in_cnt = !paddr_i[11] && (paddr_i[10:9] != 2'b00) && (cnt_idx < 4'(NUM_CNT));
    assign mapped = (paddr_i[1:0] == 2'b00) && (in_cfg || in_rate_rg || in_stat || in_cnt);
    // Zero wait states: the access phase always completes unless frozen
    assign pready_o = clk_en_i;

    // Read mux; auto mode shows negotiated speed and duplex
    always_comb begin
        next_rdata = 32'h0;
        if (in_cfg) begin
            next_rdata[8:0] = cfg[reg_port];
            if (cfg[reg_port][CFG_AUTO]) begin
                next_rdata[CFG_SPD_LO +: 2] = neg_speed_i[reg_port];
                next_rdata[CFG_DUPLEX] = neg_duplex_i[reg_port];
            end
        end else if (in_rate_rg) begin
            next_rdata[12:0] = in_rate[reg_port];
            next_rdata[RATE_EG_LO +: 13] = eg_rate[reg_port];
        end else if (in_stat) begin
            next_rdata[6:0] = {eg_over[reg_port], in_over[reg_port], pause_req_o[reg_port],
                               link_duplex_o[reg_port], link_speed_o[reg_port], link_q[reg_port]};
        end else if (in_cnt) begin
            next_rdata = cnt[cnt_port][cnt_idx];
        end
    end

    // Read data and error are captured in the setup cycle
    always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            prdata_o <= 32'h0;
            pslverr_o <= 1'b0;
        end else if (clk_en_i && setup) begin
            prdata_o <= next_rdata;
            pslverr_o <= !mapped;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Refill tick for all rate meters
    always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            tick_cnt <= 16'h0;
            tick <= 1'b0;
        end else if (clk_en_i) begin
            tick <= (tick_cnt == 16'(REFILL - 1));
            tick_cnt <= (tick_cnt == 16'(REFILL - 1)) ? 16'h0 : 16'(tick_cnt + 16'h1);
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Per-port logic
    genvar p;
    generate
        for (p = 0; p < NP; p++) begin : g_port
            logic signed [23:0] in_cred, eg_cred;
            logic rx_bad, jumbo_ok, rx_drop, rx_fwd;
            spc_rx_evt_t rx;
            spc_tx_evt_t tx;
            assign rx = rx_evt_i[p];
            assign tx = tx_evt_i[p];

            // Link pin crosses three flops; a change counts once stages 2 and 3 agree
            always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
                if (!reset_n_i) begin
                    lk_s1[p] <= 1'b0;
                    lk_s2[p] <= 1'b0;
                    lk_s3[p] <= 1'b0;
                    link_q[p] <= 1'b0;
                end else if (clk_en_i) begin
                    lk_s1[p] <= link_up_i[p];
                    lk_s2[p] <= lk_s1[p];
                    lk_s3[p] <= lk_s2[p];
                    if (lk_s2[p] == lk_s3[p]) begin
                        link_q[p] <= lk_s3[p];
                    end
                end
            end

            // Software settings; forced speed/duplex held while auto is on
            always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
                if (!reset_n_i) begin
                    cfg[p] <= CFG_RESET;
                    in_rate[p] <= 13'h0;
                    eg_rate[p] <= 13'h0;
                end else if (wr_stb && reg_port == 5'(p)) begin
                    if (in_cfg) begin
                        cfg[p] <= pwdata_i[8:0];
                        if (cfg[p][CFG_AUTO]) begin
                            cfg[p][CFG_DUPLEX:CFG_SPD_LO] <= cfg[p][CFG_DUPLEX:CFG_SPD_LO];
                        end
                    end
                    // Out-of-range rates are ignored rather than clipped
                    if (in_rate_rg && pwdata_i[12:0] <= 13'(RATE_MAX)) begin
                        in_rate[p] <= pwdata_i[12:0];
                    end
                    if (in_rate_rg && pwdata_i[28:16] <= 13'(RATE_MAX)) begin
                        eg_rate[p] <= pwdata_i[28:16];
                    end
                end
            end

            // Config word settings reach the datapath only between frames; rate settings reach the meters at once
            always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
                if (!reset_n_i) begin
                    act[p] <= CFG_RESET;
                end else if (clk_en_i && !rx.busy && !tx.busy) begin
                    act[p] <= cfg[p];
                end
            end

            // Rate meters: refill per tick, frame length debits on completion
            always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
                if (!reset_n_i) begin
                    in_cred <= 24'sh0;
                    eg_cred <= 24'sh0;
                end else if (clk_en_i) begin
                    in_cred <= in_cred + (tick ? $signed({10'h0, in_rate[p], 1'b0}) : 24'sh0)
                               - ((rx.eof && rx_fwd) ? $signed({10'h0, rx.len}) : 24'sh0);
                    eg_cred <= eg_cred + (tick ? $signed({10'h0, eg_rate[p], 1'b0}) : 24'sh0)
                               - ((tx.done && tx.ok) ? $signed({10'h0, tx.len}) : 24'sh0);
                    // Signed compare, so a debt is not mistaken for a full bucket
                    if (in_cred > $signed(24'(BURST_BYTES)) || in_rate[p] == 13'h0) begin
                        in_cred <= 24'(BURST_BYTES);
                    end
                    if (eg_cred > $signed(24'(BURST_BYTES)) || eg_rate[p] == 13'h0) begin
                        eg_cred <= 24'(BURST_BYTES);
                    end
                end
            end
            assign in_over[p] = in_cred[23];
            assign eg_over[p] = eg_cred[23];

            // Frame classification
            assign jumbo_ok = rx.jumbo && act[p][CFG_JUMBO];
            assign rx_bad = rx.crc_err || rx.runt || (rx.over && !jumbo_ok);
            assign rx_drop = !act[p][CFG_EN] || rx_bad
                             || (act[p][CFG_SECURE] && !rx.sa_known)
                             || (act[p][CFG_STORM] && rx.bcast && storm_over_i[p])
                             || (!act[p][CFG_FC] && (rx_congest_i[p] || in_over[p]));
            assign rx_fwd = rx.eof && !rx_drop;
            assign rx_forward_o[p] = clk_en_i && rx_fwd;
            assign pause_req_o[p] = act[p][CFG_EN] && act[p][CFG_FC]
                                    && (rx_congest_i[p] || in_over[p]);
            assign tx_enable_o[p] = act[p][CFG_EN] && link_q[p] && !eg_over[p];
            assign learn_en_o[p] = act[p][CFG_EN] && !act[p][CFG_SECURE];
            assign force_mode_o[p] = !act[p][CFG_AUTO];
            assign link_speed_o[p] = act[p][CFG_AUTO] ? neg_speed_i[p] : act[p][CFG_SPD_LO +: 2];
            assign link_duplex_o[p] = act[p][CFG_AUTO] ? neg_duplex_i[p] : act[p][CFG_DUPLEX];
            assign broadcast_storm_filter_enable_o[p] = act[p][CFG_STORM];
            assign jumbo_en_o[p] = act[p][CFG_JUMBO];

            // Statistics counters, wrapping at 32 bits
            always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
                if (!reset_n_i) begin
                    for (int k = 0; k < NUM_CNT; k++) begin
                        cnt[p][k] <= 32'h0;
                    end
                end else if (clk_en_i) begin
                    if (tx.done && tx.ok) begin
                        cnt[p][CNT_TX_GOOD] <= cnt[p][CNT_TX_GOOD] + 32'h1;
                    end
                    if (tx.done && !tx.ok) begin
                        cnt[p][CNT_TX_BAD] <= cnt[p][CNT_TX_BAD] + 32'h1;
                    end
                    if (tx.abort) begin
                        cnt[p][CNT_TX_ABORT] <= cnt[p][CNT_TX_ABORT] + 32'h1;
                    end
                    if (tx.collision) begin
                        cnt[p][CNT_COLL] <= cnt[p][CNT_COLL] + 32'h1;
                    end
                    if (rx.eof && !rx_bad) begin
                        cnt[p][CNT_RX_GOOD] <= cnt[p][CNT_RX_GOOD] + 32'h1;
                    end
                    if (rx.eof && rx_bad) begin
                        cnt[p][CNT_RX_BAD] <= cnt[p][CNT_RX_BAD] + 32'h1;
                    end
                    if (rx.eof && rx_drop) begin
                        cnt[p][CNT_DROP] <= cnt[p][CNT_DROP] + 32'h1;
                    end
                    if (rx.eof && !rx_bad && rx.bcast) begin
                        cnt[p][CNT_BCAST] <= cnt[p][CNT_BCAST] + 32'h1;
                    end
                    if (rx.eof && !rx_bad && rx.mcast) begin
                        cnt[p][CNT_MCAST] <= cnt[p][CNT_MCAST] + 32'h1;
                    end
                end
            end
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////////
    // Checks on port 0
    default clocking cb @(posedge sys_clk_i); endclocking
    default disable iff (!reset_n_i);

    a_disabled_no_fwd: assert property (!act[0][CFG_EN] |-> !rx_forward_o[0] && !tx_enable_o[0])
        else $error("disabled port forwarded or transmitted");
    a_auto_keeps_spd: assert property (wr_stb && in_cfg && reg_port == 5'h0 && cfg[0][CFG_AUTO]
        |=> $stable(cfg[0][CFG_DUPLEX:CFG_SPD_LO]))
        else $error("forced speed changed in auto mode");
    a_force_speed_out: assert property (!act[0][CFG_AUTO] |-> link_speed_o[0] == act[0][CFG_SPD_LO +: 2])
        else $error("forced speed not applied");
    a_pause_on_congest: assert property (act[0][CFG_EN] && act[0][CFG_FC] && rx_congest_i[0]
        |-> pause_req_o[0])
        else $error("no pause when congested");
    a_drop_no_fc: assert property (clk_en_i && rx_evt_i[0].eof && !act[0][CFG_FC] && rx_congest_i[0]
        |=> cnt[0][CNT_DROP] == $past(cnt[0][CNT_DROP]) + 32'h1)
        else $error("congested frame not dropped");
    a_rate_range: assert property (in_rate[0] <= 13'(RATE_MAX) && eg_rate[0] <= 13'(RATE_MAX))
        else $error("rate above limit stored");
    a_secure_unknown: assert property (act[0][CFG_SECURE] && !rx_evt_i[0].sa_known
        |-> !rx_forward_o[0] && !learn_en_o[0])
        else $error("secure port accepted unknown source");
    a_tx_good_count: assert property (clk_en_i && tx_evt_i[0].done && tx_evt_i[0].ok
        |=> cnt[0][CNT_TX_GOOD] == $past(cnt[0][CNT_TX_GOOD]) + 32'h1)
        else $error("good tx not counted");
    a_link_settles: assert property ((clk_en_i && $stable(link_up_i[0])) [*5]
        |-> link_q[0] == link_up_i[0])
        else $error("link status not following pin");

    c_pause: cover property (pause_req_o[0]);
    c_drop: cover property (rx_evt_i[0].eof && rx_drop_any());
    c_apb_read: cover property (psel_i && penable_i && !pwrite_i && in_cnt);

    function automatic logic rx_drop_any();
        return !rx_forward_o[0];
    endfunction
endmodule

// ### spc_link_peer.sv
// Behavioural link partner and frame source for one switch port
`timescale 1ns/100ps
module spc_link_peer (
    // Clock
    input wire logic sys_clk_i,
    // Acceptance seen from the device
    input wire logic fwd_i,
    // Frame activity towards the device
    output spc_pkg::spc_rx_evt_t rx_o,
    output spc_pkg::spc_tx_evt_t tx_o,
    output logic fwd_seen_o
);
    import spc_pkg::*;
    initial begin
        rx_o = '0;
        tx_o = '0;
        fwd_seen_o = 1'b0;
    end
    ////////////////////////////////////////////////////////////////////////////
    // One received frame; stale fields are inverted so nothing reads them as valid
    task automatic send_rx(input spc_rx_evt_t e);
        spc_rx_evt_t s;
        s = ~e;
        s.busy = 1'b0;
        s.eof = 1'b0;
        e.busy = 1'b1;
        @(posedge sys_clk_i);
        rx_o <= '{busy: 1'b1, default: '0};
        repeat (3) @(posedge sys_clk_i);
        e.eof = 1'b1;
        rx_o <= e;
        @(posedge sys_clk_i);
        fwd_seen_o = fwd_i;
        rx_o <= s;
    endtask
    ////////////////////////////////////////////////////////////////////////////
    // One transmitted frame: busy, optional collision, then done or abort
    task automatic send_tx(input logic ok, input logic ab, input logic coll);
        spc_tx_evt_t t;
        t = '0;
        t.busy = 1'b1;
        t.len = 14'h0040;
        @(posedge sys_clk_i);
        tx_o <= t;
        t.collision = coll;
        @(posedge sys_clk_i);
        tx_o <= t;
        t.collision = 1'b0;
        t.done = !ab;
        t.ok = ok;
        t.abort = ab;
        @(posedge sys_clk_i);
        tx_o <= t;
        @(posedge sys_clk_i);
        tx_o <= '0;
    endtask
endmodule

// ### switch_port_control_stats_tb_top.sv
// Self-checking bench for the port control and statistics block
`timescale 1ns/100ps
module switch_port_control_stats_tb_top;
    import spc_pkg::*;
    localparam int NP = NUM_PORTS;
    logic sys_clk_i, reset_n_i, psel, penable, pwrite, pready, pslverr, err, fwd_seen;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic [NP-1:0] link_up, neg_duplex, rx_congest, storm_over, rx_forward, tx_enable, pause_req;
    logic [NP-1:0] learn_en, force_mode, link_duplex, storm_en, jumbo_en;
    logic [NP-1:0][1:0] neg_speed, link_speed;
    spc_rx_evt_t rx_evt [NP];
    spc_tx_evt_t tx_evt [NP];
    spc_rx_evt_t peer_rx;
    spc_tx_evt_t peer_tx;
    logic [31:0] exp_cnt [NUM_CNT];
    int miscompares, comparisons;

    spc_port_ctrl #(.NP(NP), .REFILL(10)) u_dut (.sys_clk_i(sys_clk_i), .reset_n_i(reset_n_i),
        .clk_en_i(1'b1), .psel_i(psel), .penable_i(penable), .pwrite_i(pwrite), .paddr_i(paddr),
        .pwdata_i(pwdata), .prdata_o(prdata), .pready_o(pready), .pslverr_o(pslverr),
        .link_up_i(link_up), .neg_speed_i(neg_speed), .neg_duplex_i(neg_duplex), .rx_evt_i(rx_evt),
        .tx_evt_i(tx_evt), .rx_congest_i(rx_congest), .storm_over_i(storm_over),
        .rx_forward_o(rx_forward), .tx_enable_o(tx_enable), .pause_req_o(pause_req),
        .learn_en_o(learn_en), .force_mode_o(force_mode), .link_speed_o(link_speed),
        .link_duplex_o(link_duplex), .broadcast_storm_filter_enable_o(storm_en), .jumbo_en_o(jumbo_en));
    spc_link_peer u_peer (.sys_clk_i(sys_clk_i), .fwd_i(rx_forward[0]), .rx_o(peer_rx), .tx_o(peer_tx),
        .fwd_seen_o(fwd_seen));

    // Only port 0 carries traffic; the rest stay idle
    always_comb begin
        for (int i = 0; i < NP; i++) begin
            rx_evt[i] = (i == 0) ? peer_rx : '0;
            tx_evt[i] = (i == 0) ? peer_tx : '0;
        end
    end
    // Clock
    initial begin
        sys_clk_i = 1'b0;
        forever #2.5 sys_clk_i = ~sys_clk_i;
    end
    ////////////////////////////////////////////////////////////////////////////
    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
        comparisons++;
        if (got !== exp) begin
            miscompares++;
            $display("wrong value at %0t: %s got %h expected %h", $time, what, got, exp);
        end
    endtask
    // APB transfer; writes are given a few edges so the active copy can reload
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
        @(posedge sys_clk_i);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge sys_clk_i);
        penable <= 1'b1;
        @(posedge sys_clk_i);
        while (pready !== 1'b1) @(posedge sys_clk_i);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        if (wr) repeat (3) @(posedge sys_clk_i);
    endtask
    task automatic rd_chk(input logic [11:0] a, input logic [31:0] exp, input string what);
        apb(1'b0, a, 32'h0);
        chk(rd, exp, what);
    endtask
    // Flags: crc, runt, over, jumbo, bcast, mcast, known source
    function automatic spc_rx_evt_t fr(input logic [6:0] f);
        fr = '0;
        {fr.crc_err, fr.runt, fr.over, fr.jumbo, fr.bcast, fr.mcast, fr.sa_known} = f;
        fr.len = 14'h0040;
    endfunction
    // Frame with expected acceptance; counter expectations follow the flags
    task automatic rx_frame(input logic [6:0] f, input logic fwd);
        u_peer.send_rx(fr(f));
        chk(32'(fwd_seen), 32'(fwd), "forward");
        if (f[6:4] == 3'h0) begin
            exp_cnt[CNT_RX_GOOD]++;
            exp_cnt[CNT_BCAST] += 32'(f[2]);
            exp_cnt[CNT_MCAST] += 32'(f[1]);
        end else begin
            exp_cnt[CNT_RX_BAD]++;
        end
        exp_cnt[CNT_DROP] += 32'(!fwd);
    endtask
    ////////////////////////////////////////////////////////////////////////////
    task automatic t_reset();
        rd_chk(CFG_BASE, 32'(CFG_RESET), "cfg reset");
        rd_chk(RATE_BASE, 32'h0, "rate reset");
        apb(1'b0, 12'h060, 32'h0);
        chk(32'(err), 32'h1, "unmapped");
        $display("reset test done");
    endtask
    task automatic t_speed();
        link_up[0] <= 1'b1;
        neg_speed[0] <= 2'h2;
        neg_duplex[0] <= 1'b1;
        repeat (8) @(posedge sys_clk_i);
        rd_chk(STAT_BASE, 32'h0000_000D, "status");
        chk(32'(link_speed[0]), 32'h2, "auto speed");
        apb(1'b1, CFG_BASE, 32'h0000_001F);
        rd_chk(CFG_BASE, 32'h0000_001B, "auto ignores speed");
        apb(1'b1, CFG_BASE, 32'h0000_0001);
        apb(1'b1, CFG_BASE, 32'h0000_0005);
        rd_chk(CFG_BASE, 32'h0000_0005, "forced cfg");
        chk(32'({force_mode[0], link_speed[0], link_duplex[0]}), 32'h0A, "forced");
        $display("speed test done");
    endtask
    task automatic t_rx();
        rx_frame(7'h05, 1'b1);
        rx_frame(7'h03, 1'b1);
        rx_frame(7'h41, 1'b0);
        rx_frame(7'h21, 1'b0);
        rx_frame(7'h11, 1'b0);
        apb(1'b1, CFG_BASE, 32'h0000_0105);
        chk(32'(jumbo_en[0]), 32'h1, "jumbo enable");
        rx_frame(7'h09, 1'b1);
        chk(32'(tx_enable[0]), 32'h1, "tx on");
        apb(1'b1, CFG_BASE, 32'h0000_0004);
        chk(32'(tx_enable[0]), 32'h0, "tx off");
        rx_frame(7'h01, 1'b0);
        $display("receive test done");
    endtask
    task automatic t_flow();
        apb(1'b1, CFG_BASE, 32'h0000_0005);
        rx_congest[0] <= 1'b1;
        rx_frame(7'h01, 1'b0);
        chk(32'(pause_req[0]), 32'h0, "no pause");
        apb(1'b1, CFG_BASE, 32'h0000_0025);
        chk(32'(pause_req[0]), 32'h1, "pause");
        rx_congest[0] <= 1'b0;
        repeat (3) @(posedge sys_clk_i);
        chk(32'(pause_req[0]), 32'h0, "pause end");
        apb(1'b1, CFG_BASE, 32'h0000_0045);
        chk(32'(learn_en[0]), 32'h0, "no learning");
        rx_frame(7'h00, 1'b0);
        rx_frame(7'h01, 1'b1);
        $display("flow and security test done");
    endtask
    task automatic t_tx();
        u_peer.send_tx(1'b1, 1'b0, 1'b0);
        u_peer.send_tx(1'b0, 1'b0, 1'b0);
        u_peer.send_tx(1'b0, 1'b1, 1'b0);
        u_peer.send_tx(1'b1, 1'b0, 1'b1);
        exp_cnt[CNT_TX_GOOD] += 32'h2;
        exp_cnt[CNT_TX_BAD]++;
        exp_cnt[CNT_TX_ABORT]++;
        exp_cnt[CNT_COLL]++;
        for (int k = 0; k < NUM_CNT; k++) begin
            rd_chk(CNT_BASE + 12'(4 * k), exp_cnt[k], "counter");
        end
        $display("counter test done");
    endtask
    task automatic t_rate();
        apb(1'b1, RATE_BASE, 32'h1F40_1F41);
        rd_chk(RATE_BASE, 32'h1F40_0000, "ingress over range");
        apb(1'b1, RATE_BASE, 32'h1F41_1F40);
        rd_chk(RATE_BASE, 32'h1F40_1F40, "egress over range");
        apb(1'b1, RATE_BASE, 32'h0);
        storm_over[0] <= 1'b1;
        u_peer.send_rx(fr(7'h05));
        chk(32'(fwd_seen), 32'h1, "storm filter off");
        apb(1'b1, CFG_BASE, 32'h0000_0085);
        chk(32'(storm_en[0]), 32'h1, "storm enable");
        u_peer.send_rx(fr(7'h05));
        chk(32'(fwd_seen), 32'h0, "storm filter on");
        $display("rate and storm test done");
    endtask
    ////////////////////////////////////////////////////////////////////////////
    task automatic end_of_test();
        $display("comparisons %0d miscompares %0d", comparisons, miscompares);
        if (miscompares == 0 && comparisons > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask
    // Main sequence
    initial begin
        {psel, penable, pwrite, paddr, pwdata} = '0;
        {link_up, neg_speed, neg_duplex, rx_congest, storm_over} = '0;
        reset_n_i = 1'b0;
        miscompares = 0;
        comparisons = 0;
        for (int k = 0; k < NUM_CNT; k++) exp_cnt[k] = '0;
        repeat (3) @(posedge sys_clk_i);
        reset_n_i <= 1'b1;
        t_reset();
        t_speed();
        t_rx();
        t_flow();
        t_tx();
        t_rate();
        end_of_test();
    end
    // Watchdog: the whole sequence needs well under 2000 cycles
    initial begin
        #100000;
        miscompares++;
        $display("wrong value at %0t: watchdog expired", $time);
        end_of_test();
    end
endmodule
